// *** pkg/adc_flag_consts.svh ***
`ifndef ADC_FLAG_CONSTS_SVH
`define ADC_FLAG_CONSTS_SVH

// Register word offsets (byte addresses on the plain register port)
`define OFS_CTRL    8'h00
`define OFS_MODE    8'h04
`define OFS_CHEN    8'h10
`define OFS_CHDIS   8'h14
`define OFS_CHSTAT  8'h18
`define OFS_STATUS  8'h1c
`define OFS_LAST    8'h20
`define OFS_IRQEN   8'h24
`define OFS_IRQST   8'h28
`define OFS_CHRES0  8'h30

// Field positions
`define CTRL_START  1
`define MODE_SLEEP  5
`define ST_READY    16
`define ST_GOVR     17
`define ST_OVR0     8
`define LAST_CH0    16

// Sticky interrupt bits
`define IRQ_DONE    0
`define IRQ_READY   1
`define IRQ_OVR     2
`define IRQ_W       3

`define ZERO32      32'h0000_0000

`endif

// *** pkg/adc_flag_pkg.sv ***
package adc_flag_pkg;

   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   // End of conversion report from the analog core
   typedef struct packed {
      logic valid;
      logic [2:0] chan;
      logic [9:0] data;
   } conv_end_t;

   typedef enum logic [1:0] {
      PWR_AWAKE,
      PWR_ARMED,
      PWR_ASLEEP
   } pwr_state_t;

endpackage

// *** core/adc_status_flag_logic.sv ***
// Contract
// - Only last-result reads clear data ready
// - Disabled channel end never sets data ready
// - Channel read never blocks data ready set
// - Disable elsewhere still stores, sets ready
// - Status read still updates general overrun
// - Channel read still sets general overrun
// - Disable elsewhere still raises both overruns
// - Status read clears channel overrun unless a new one is set that cycle
// - Result reads clear that channel's done
// - Channel disabled mid-conversion never flags done
// - Channel read clears only its own done
// - Sleep taken only after next conversion ends
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "adc_flag_consts.svh"

module adc_status_flag_logic #(
   parameter int NCH = 8,
   parameter int DW = 10
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Register port
   input wire adc_flag_pkg::reg_req_t regReq,
   output logic [31:0] regRdata,
   // Analog core
   input wire adc_flag_pkg::conv_end_t convEnd,
   output logic startConv,
   output logic sleepOut,
   // Interrupt
   output logic irq
);

   // ==========================================================
   // Decode
   // ==========================================================
   logic wrCtrl, wrMode, wrChEn, wrChDis, wrIrqEn, wrIrqSt;
   logic rdStatus, rdLast;
   logic [NCH-1:0] rdChan;
   logic [NCH-1:0] chEn_r, done_r, ovr_r, endHit, busyDis_r;
   logic dataReady_r, govr_r, sleepSel_r, sleepOut_r, startConv_r;
   logic [DW-1:0] chRes_r [NCH];
   logic [DW-1:0] lastRes_r;
   logic [2:0] lastCh_r;
   logic busy_r;
   logic [`IRQ_W-1:0] irqSt_r, irqEn_r, irqEv;
   logic [31:0] rdNxt, regRdata_r;
   logic irq_r;
   logic endOk, endDis, ovrEv;
   adc_flag_pkg::pwr_state_t pwr_r;

   assign wrCtrl = regReq.wr && regReq.addr == `OFS_CTRL;
   assign wrMode = regReq.wr && regReq.addr == `OFS_MODE;
   assign wrChEn = regReq.wr && regReq.addr == `OFS_CHEN;
   assign wrChDis = regReq.wr && regReq.addr == `OFS_CHDIS;
   assign wrIrqEn = regReq.wr && regReq.addr == `OFS_IRQEN;
   assign wrIrqSt = regReq.wr && regReq.addr == `OFS_IRQST;
   assign rdStatus = regReq.rd && regReq.addr == `OFS_STATUS;
   assign rdLast = regReq.rd && regReq.addr == `OFS_LAST;

   // Channel result words sit four bytes apart
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : gDec
         assign rdChan[g] = regReq.rd &&
            regReq.addr == 8'(`OFS_CHRES0 + 4 * g);
         assign endHit[g] = convEnd.valid && convEnd.chan == 3'(g);
      end
   endgenerate

   // Channel state is judged by its own enable only; a disable
   // written this very cycle for another channel is irrelevant
   assign endOk = convEnd.valid && chEn_r[convEnd.chan];
   assign endDis = convEnd.valid && !chEn_r[convEnd.chan];

   // ==========================================================
   // Channel enables and in-flight disable tracking
   // ==========================================================
   // Enable and disable sit at separate addresses, never together
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         chEn_r <= '0;
      end else if (wrChEn) begin
         chEn_r <= chEn_r | regReq.wdata[NCH-1:0];
      end else if (wrChDis) begin
         chEn_r <= chEn_r & ~regReq.wdata[NCH-1:0];
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         busy_r <= 1'b0;
      end else if (startConv_r) begin
         busy_r <= 1'b1;
      end else if (convEnd.valid) begin
         busy_r <= 1'b0;
      end
   end

   // Remember channels turned off while a conversion runs, so that
   // its late end raises no done; an idle disable needs no memory,
   // as the enable itself already gates the flags
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         busyDis_r <= '0;
      end else if (wrChDis && busy_r) begin
         busyDis_r <= (busyDis_r & ~endHit) |
            (chEn_r & regReq.wdata[NCH-1:0]);
      end else begin
         busyDis_r <= busyDis_r & ~endHit;
      end
   end

   // ==========================================================
   // Result storage
   // ==========================================================
   // A disabled channel's end leaves both result words alone, so a
   // stale conversion never passes for a fresh one
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         lastRes_r <= '0;
         lastCh_r <= 3'h0;
         for (int i = 0; i < NCH; i++) begin
            chRes_r[i] <= '0;
         end
      end else if (endOk) begin
         lastRes_r <= convEnd.data;
         lastCh_r <= convEnd.chan;
         chRes_r[convEnd.chan] <= convEnd.data;
      end
   end

   // ==========================================================
   // Per-channel done and overrun flags
   // ==========================================================
   // Every flag gives the set priority over the read clear, so an
   // end of conversion in a read cycle is never lost
   generate
      for (g = 0; g < NCH; g++) begin : gFlag
         logic setDone, clrDone;
         // Done is set only for an enabled channel end, never
         // for one whose enable has dropped
         assign setDone = endHit[g] && chEn_r[g] && !busyDis_r[g];
         // Own read, or last read of its own data
         assign clrDone = rdChan[g] || (rdLast && lastCh_r == 3'(g));
         always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
               done_r[g] <= 1'b0;
            end else if (setDone) begin
               done_r[g] <= 1'b1;
            end else if (clrDone) begin
               done_r[g] <= 1'b0;
            end
         end
         always_ff @(posedge mclk or posedge sys_rst) begin
            if (sys_rst) begin
               ovr_r[g] <= 1'b0;
            end else if (setDone && done_r[g]) begin
               ovr_r[g] <= 1'b1;
            end else if (rdStatus) begin
               ovr_r[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // ==========================================================
   // Global data ready and general overrun
   // ==========================================================
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         dataReady_r <= 1'b0;
      end else if (endOk) begin
         dataReady_r <= 1'b1;
      end else if (rdLast) begin
         // Channel reads leave it alone; only the last result clears
         dataReady_r <= 1'b0;
      end
   end

   // Set wins over the read clear, whatever else is read
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         govr_r <= 1'b0;
      end else if (endOk && dataReady_r) begin
         govr_r <= 1'b1;
      end else if (rdStatus) begin
         govr_r <= 1'b0;
      end
   end

   // ==========================================================
   // Start and sleep
   // ==========================================================
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         startConv_r <= 1'b0;
      end else begin
         // The visible sleep level blocks too, so a start is never
         // taken while software still sees the core asleep
         startConv_r <= wrCtrl && regReq.wdata[`CTRL_START] &&
            pwr_r != adc_flag_pkg::PWR_ASLEEP && !sleepOut_r;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sleepSel_r <= 1'b0;
      end else if (wrMode) begin
         // Only arms; an idle core stays awake until a conversion ends
         sleepSel_r <= regReq.wdata[`MODE_SLEEP];
      end
   end

   // Sleep is armed by the select and taken only at a conversion
   // end; a start after the select gets there soonest
   // Clearing the select wakes the core at once, armed or asleep
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pwr_r <= adc_flag_pkg::PWR_AWAKE;
      end else begin
         case (pwr_r)
            adc_flag_pkg::PWR_AWAKE: begin
               if (sleepSel_r) begin
                  pwr_r <= adc_flag_pkg::PWR_ARMED;
               end
            end
            adc_flag_pkg::PWR_ARMED: begin
               if (!sleepSel_r) begin
                  pwr_r <= adc_flag_pkg::PWR_AWAKE;
               end else if (convEnd.valid) begin
                  pwr_r <= adc_flag_pkg::PWR_ASLEEP;
               end
            end
            adc_flag_pkg::PWR_ASLEEP: begin
               if (!sleepSel_r) begin
                  pwr_r <= adc_flag_pkg::PWR_AWAKE;
               end
            end
            default: pwr_r <= adc_flag_pkg::PWR_AWAKE;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sleepOut_r <= 1'b0;
      end else begin
         sleepOut_r <= pwr_r == adc_flag_pkg::PWR_ASLEEP;
      end
   end

   // ==========================================================
   // Interrupts
   // ==========================================================
   // Overrun is an event: a second end before its done is read, or
   // a new result while the previous one is still unread
   assign ovrEv = |(endHit & chEn_r & ~busyDis_r & done_r) |
      (endOk & dataReady_r);
   assign irqEv = {ovrEv, endOk, |(endHit & chEn_r & ~busyDis_r)};

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         irqSt_r <= '0;
      end else if (wrIrqSt) begin
         // Ones clear, but an event in the same cycle wins
         irqSt_r <= (irqSt_r & ~regReq.wdata[`IRQ_W-1:0]) | irqEv;
      end else begin
         irqSt_r <= irqSt_r | irqEv;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         irqEn_r <= '0;
      end else if (wrIrqEn) begin
         irqEn_r <= regReq.wdata[`IRQ_W-1:0];
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_r <= 1'b0;
      end else begin
         // The mask gates only the pin; status bits keep collecting
         irq_r <= |(irqSt_r & irqEn_r);
      end
   end

   // ==========================================================
   // Read data, one cycle after the strobe
   // ==========================================================
   // Read side effects act at the strobe edge; the word returned is
   // the state just before them
   always_comb begin
      rdNxt = `ZERO32;
      if (regReq.rd) begin
         case (regReq.addr)
            `OFS_MODE: rdNxt[`MODE_SLEEP] = sleepSel_r;
            `OFS_CHSTAT: rdNxt[NCH-1:0] = chEn_r;
            `OFS_STATUS: begin
               rdNxt[NCH-1:0] = done_r;
               rdNxt[`ST_OVR0 +: NCH] = ovr_r;
               rdNxt[`ST_READY] = dataReady_r;
               rdNxt[`ST_GOVR] = govr_r;
            end
            `OFS_LAST: begin
               rdNxt[DW-1:0] = lastRes_r;
               rdNxt[`LAST_CH0 +: 3] = lastCh_r;
            end
            `OFS_IRQEN: rdNxt[`IRQ_W-1:0] = irqEn_r;
            `OFS_IRQST: rdNxt[`IRQ_W-1:0] = irqSt_r;
            default: begin
               for (int i = 0; i < NCH; i++) begin
                  if (rdChan[i]) begin
                     rdNxt[DW-1:0] = chRes_r[i];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         regRdata_r <= `ZERO32;
      end else begin
         regRdata_r <= rdNxt;
      end
   end

   assign regRdata = regRdata_r;
   assign startConv = startConv_r;
   assign sleepOut = sleepOut_r;
   assign irq = irq_r;

endmodule // adc_status_flag_logic

// *** bench/adc_core_model.sv ***
`timescale 1ns/100ps

module adc_core_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Conversion requests
   input wire logic startConv,
   input wire logic trig,
   input wire logic [2:0] trigCh,
   input wire logic [9:0] trigData,
   // Result report
   output adc_flag_pkg::conv_end_t convEnd
);
   // ==========
   // Conversion end
   // Idle data toggles so a stale value never passes for a result
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         convEnd <= '0;
      end else if (startConv || trig) begin
         convEnd <= '{1'b1, trigCh, trigData};
      end else begin
         convEnd <= '{1'b0, convEnd.chan, ~convEnd.data};
      end
   end
endmodule // adc_core_model

// *** bench/adc_flag_checker.sv ***
`timescale 1ns/100ps
`include "adc_flag_consts.svh"

module adc_flag_checker (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Register port
   input wire adc_flag_pkg::reg_req_t regReq,
   input wire logic [31:0] regRdata,
   // Core and interrupt
   input wire adc_flag_pkg::conv_end_t convEnd,
   input wire logic startConv,
   input wire logic sleepOut,
   input wire logic irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);

   // ==========
   // Start writes, and reads with no conversion end beside them
   logic startWr;
   assign startWr = regReq.wr && regReq.addr == `OFS_CTRL
      && regReq.wdata[`CTRL_START];
   sequence statRd;
      regReq.rd && regReq.addr == `OFS_STATUS && !convEnd.valid;
   endsequence
   sequence lastRd;
      regReq.rd && regReq.addr == `OFS_LAST && !convEnd.valid;
   endsequence
   sequence chanRd;
      regReq.rd && regReq.addr[7:4] inside {4'h3, 4'h4} && !convEnd.valid;
   endsequence

   // ==========
   // Properties
   a_rdata_idle:
   assert property (!regReq.rd |=> regRdata == 32'h0)
      else $error("read data outside a read");
   a_start_cause:
   assert property (startConv |-> $past(startWr))
      else $error("start pulse without start write");
   a_start_asleep:
   assert property (startWr && sleepOut |=> !startConv)
      else $error("start taken while asleep");
   a_unmapped_zero:
   assert property (regReq.rd && regReq.addr >= 8'h50 |=> regRdata == 32'h0)
      else $error("unmapped read not zero");
   a_irq_masked:
   assert property (regReq.wr && regReq.addr == `OFS_IRQEN
      && regReq.wdata[2:0] == 3'h0 |-> ##2 !irq)
      else $error("masked interrupt still high");
   a_sleep_cause:
   assert property ($rose(sleepOut) |->
      $past(convEnd.valid) || $past(convEnd.valid, 2))
      else $error("sleep without conversion end");
   a_ready_cleared:
   assert property (lastRd ##1 statRd |=> !regRdata[`ST_READY])
      else $error("data ready kept after last read");
   a_ready_kept:
   assert property (statRd ##1 chanRd ##0 regRdata[`ST_READY] ##1 statRd
      |=> regRdata[`ST_READY])
      else $error("channel read cleared data ready");
   a_ovr_cleared:
   assert property (statRd ##1 statRd |=>
      regRdata[15:8] == 8'h00 && !regRdata[`ST_GOVR])
      else $error("overrun kept after status read");
endmodule // adc_flag_checker

bind adc_status_flag_logic adc_flag_checker adc_flag_checker_inst (
   .mclk(mclk), .sys_rst(sys_rst), .regReq(regReq), .regRdata(regRdata),
   .convEnd(convEnd), .startConv(startConv), .sleepOut(sleepOut),
   .irq(irq));

// *** bench/adc_status_flag_logic_bench.sv ***
`timescale 1ns/100ps

module adc_status_flag_logic_bench;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [31:0] val;
      logic ev;
      logic [2:0] ch;
      logic [9:0] dat;
   } row_t;
   localparam logic [7:0] ST = 8'h1c;
   localparam logic [7:0] LA = 8'h20;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   adc_flag_pkg::reg_req_t regReq = '0;
   adc_flag_pkg::reg_req_t pend = '0;
   adc_flag_pkg::conv_end_t convEnd;
   logic [31:0] regRdata;
   logic startConv, sleepOut, irq;
   logic trig = 1'b0;
   logic [2:0] trigCh = 3'h0;
   logic [9:0] trigData = 10'h000;
   logic c0 = 1'b0, c1 = 1'b0, c2 = 1'b0;
   logic [31:0] e0 = '0, e1 = '0, e2 = '0;
   int bad_count = 0, num_checks = 0, cycles = 0, starts = 0;
   row_t rows [$];

   adc_status_flag_logic adc_status_flag_logic_inst (.mclk(mclk),
      .sys_rst(sys_rst), .regReq(regReq), .regRdata(regRdata),
      .convEnd(convEnd), .startConv(startConv), .sleepOut(sleepOut),
      .irq(irq));
   adc_core_model adc_core_model_inst (.mclk(mclk), .sys_rst(sys_rst),
      .startConv(startConv), .trig(trig), .trigCh(trigCh),
      .trigData(trigData), .convEnd(convEnd));

   // ==========
   // Row helpers
   function automatic row_t r(logic [7:0] a, logic [31:0] x);
      return '{1'b1, 1'b0, a, x, 1'b0, 3'h0, 10'h000};
   endfunction
   function automatic row_t w(logic [7:0] a, logic [31:0] d);
      return '{1'b0, 1'b1, a, d, 1'b0, 3'h0, 10'h000};
   endfunction
   function automatic row_t e(logic [2:0] c, logic [9:0] d);
      return '{1'b0, 1'b0, 8'h00, 32'h0, 1'b1, c, d};
   endfunction
   function automatic row_t co(row_t a, row_t b);
      return a | b;
   endfunction

   // ==========
   // Stimulus and checks
   // Requests lag one cycle so they meet the core model's reported end
   task automatic step(row_t x);
      @(posedge mclk);
      pend <= '{x.addr, x.val, x.wr, x.rd};
      trig <= x.ev;
      trigCh <= x.ch;
      trigData <= x.dat;
      c0 <= x.rd;
      e0 <= x.val;
      #1;
   endtask
   task automatic cmp(logic [31:0] got, logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic cmpBit(logic got, logic exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t flag %b want %b", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      if (bad_count == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   always #5 mclk = ~mclk;
   always @(posedge mclk) begin
      regReq <= pend;
      {c1, c2} <= {c0, c1};
      {e1, e2} <= {e0, e1};
      cycles <= cycles + 1;
      starts <= starts + int'(startConv);
      if (cycles == 1000) begin
         bad_count++;
         stop_test;
      end
   end
   always @(negedge mclk) begin
      if (c2) begin
         cmp(regRdata, e2);
      end
   end

   initial begin
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      #1;
      cmp(regRdata, 32'h0);
      cmpBit(irq | sleepOut | startConv, 1'b0);
      rows = '{w(8'h10, 32'h0f), e(3'h2, 10'h155),
         r(ST, 32'h10004),
         r(8'h38, 32'h155),
         r(ST, 32'h10000),
         r(LA, 32'h20155), r(ST, 32'h0),
         e(3'h1, 10'h0aa), e(3'h1, 10'h0ab),
         r(ST, 32'h30202), r(ST, 32'h10002),
         e(3'h5, 10'h3ff), r(ST, 32'h10002),
         r(LA, 32'h100ab),
         e(3'h0, 10'h0c0), e(3'h1, 10'h0c1), r(ST, 32'h30003),
         co(r(8'h38, 32'h155), e(3'h0, 10'h0c2)),
         r(8'h30, 32'h0c2),
         co(r(ST, 32'h30102), e(3'h0, 10'h0c3)),
         r(LA, 32'h0c3),
         co(r(ST, 32'h20002), e(3'h3, 10'h0d3)),
         r(ST, 32'h1000a),
         co(r(LA, 32'h300d3), e(3'h5, 10'h3ff)), r(ST, 32'h2),
         co(w(8'h14, 32'h4), e(3'h0, 10'h0e0)), r(ST, 32'h10003),
         co(w(8'h14, 32'h8), e(3'h0, 10'h0e1)), r(ST, 32'h30103),
         r(LA, 32'h0e1),
         r(8'h18, 32'h3), w(8'h14, 32'h1),
         co(r(8'h34, 32'h0c1), e(3'h0, 10'h0f0)),
         r(ST, 32'h0), r(8'h24, 32'h0),
         r(8'h28, 32'h7), w(8'h80, 32'hffffffff), r(8'h80, 32'h0)};
      foreach (rows[i]) step(rows[i]);
      step(w(8'h24, 32'h7));
      repeat (4) step('0);
      cmpBit(irq, 1'b1);
      step(w(8'h24, 32'h0));
      repeat (4) step('0);
      cmpBit(irq, 1'b0);
      step(w(8'h24, 32'h7));
      step(w(8'h28, 32'h7));
      step(r(8'h28, 32'h0));
      repeat (4) step('0);
      cmpBit(irq, 1'b0);
      step(w(8'h04, 32'h20));
      repeat (6) step('0);
      cmpBit(sleepOut, 1'b0);
      step(w(8'h00, 32'h2));
      repeat (6) step('0);
      cmpBit(sleepOut, 1'b1);
      step(w(8'h00, 32'h2));
      step(w(8'h04, 32'h0));
      repeat (6) step('0);
      cmpBit(sleepOut, 1'b0);
      // Reset in mid-run with flags and the interrupt raised
      step(e(3'h1, 10'h0f1));
      repeat (3) step('0);
      cmpBit(irq, 1'b1);
      sys_rst <= 1'b1;
      step('0);
      cmpBit(irq | sleepOut | startConv, 1'b0);
      cmp(regRdata, 32'h0);
      sys_rst <= 1'b0;
      step(r(ST, 32'h0));
      repeat (3) step('0);
      cmp(32'(starts), 32'h1);
      stop_test;
   end
endmodule // adc_status_flag_logic_bench
